// [verilog/sac_ctrl.sv]
/*
 * Conversion sequencer of an 8-bit successive-approximation converter.
 * Host strobes arrive asynchronously and are synchronised here. The analog
 * comparator is outside: it answers whether the trial code is below the input.
 * Converter clock is either a divided system enable or an external clock pin.
 */
// Notes on behaviour
// - Restart mid-conversion aborts and begins afresh.
// - Aborted conversion never updates output latch.
// - Done stays high during a restart.
// - Clock from external pin or self-clock.
// - Straight binary 8-bit result code.
// - Top transition to all ones handled.
// - Select and read clear done, drive data.
// - Free-run done pulse self-terminates near 300 ns.
`timescale 1ns/1ps
module sac_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sac_pkg::sac_strobe_t strobe_i,
    input wire logic ext_clk_sel_i,
    input wire logic ext_clk_i,
    input wire logic comp_below_i,
    output logic [7:0] trial_code_o,
    output logic sample_o,
    output logic conversion_done_n_o,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    output logic busy_o
);
    logic [2:0] sel_sync;
    logic [2:0] start_sync;
    logic [2:0] read_sync;
    logic [2:0] eclk_sync;
    logic [2:0] esel_sync;
    logic esel;
    logic sel_n;
    logic start_n;
    logic read_n;
    logic eclk;
    logic start_prev;
    logic eclk_prev;
    logic [7:0] div_cnt;
    logic [5:0] pulse_cnt;
    sac_pkg::sac_state_t state;
    logic [7:0] sar;
    logic [7:0] bit_ptr;
    logic [7:0] result;
    logic done_flag;
    logic free_pulse;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sel_sync <= sac_pkg::SYNC_RST;
            start_sync <= sac_pkg::SYNC_RST;
            read_sync <= sac_pkg::SYNC_RST;
            eclk_sync <= 3'h0;
            esel_sync <= 3'h0;
        end
        else
        begin
            sel_sync <= {sel_sync[1:0], strobe_i.sel_n};
            start_sync <= {start_sync[1:0], strobe_i.start_n};
            read_sync <= {read_sync[1:0], strobe_i.read_n};
            eclk_sync <= {eclk_sync[1:0], ext_clk_i};
            esel_sync <= {esel_sync[1:0], ext_clk_sel_i};
        end
    end

    // A level counts once the second and third stages agree
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sel_n <= 1'b1;
            start_n <= 1'b1;
            read_n <= 1'b1;
            eclk <= 1'b0;
            esel <= 1'b0;
        end
        else
        begin
            if (sel_sync[1] == sel_sync[2])
                sel_n <= sel_sync[2];
            if (start_sync[1] == start_sync[2])
                start_n <= start_sync[2];
            if (read_sync[1] == read_sync[2])
                read_n <= read_sync[2];
            if (eclk_sync[1] == eclk_sync[2])
                eclk <= eclk_sync[2];
            if (esel_sync[1] == esel_sync[2])
                esel <= esel_sync[2];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            start_prev <= 1'b1;
            eclk_prev <= 1'b0;
        end
        else
        begin
            start_prev <= start_n;
            eclk_prev <= eclk;
        end
    end

    // Start takes effect on the rising edge that ends the strobe
    wire sel_act = ~sel_n;
    wire start_rise = start_n & ~start_prev & sel_act;
    // Done falling while start is tied to it: start held low restarts once the pulse timer reaches FREE_PULSE_LAST
    wire free_start = free_pulse & (pulse_cnt == sac_pkg::FREE_PULSE_LAST);
    wire go = start_rise | free_start;
    wire read_act = sel_act & ~read_n;
    wire div_tick = (div_cnt == sac_pkg::CONV_DIV_LAST);
    wire eclk_tick = eclk & ~eclk_prev;
    // Clock select is a pin too; synchronised so a change cannot split a step
    wire conv_tick = esel ? eclk_tick : div_tick;
    wire last_bit = bit_ptr[0];
    wire keep_bit = comp_below_i;
    wire [7:0] next_sar = (keep_bit ? sar : (sar & ~bit_ptr)) | (bit_ptr >> 1);
    wire [7:0] final_code = keep_bit ? sar : (sar & ~bit_ptr);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            div_cnt <= 8'h00;
        else if (div_tick)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= sac_pkg::SAC_IDLE;
            sar <= sac_pkg::RESULT_RST;
            bit_ptr <= sac_pkg::RESULT_RST;
        end
        else if (go)
        begin
            state <= sac_pkg::SAC_CONV;
            sar <= sac_pkg::MSB_ONEHOT;
            bit_ptr <= sac_pkg::MSB_ONEHOT;
        end
        else
        begin
            case (state)
                sac_pkg::SAC_CONV:
                begin
                    if (conv_tick)
                    begin
                        sar <= next_sar;
                        bit_ptr <= bit_ptr >> 1;
                        if (last_bit)
                            state <= sac_pkg::SAC_DONE;
                    end
                end
                sac_pkg::SAC_DONE:
                    state <= sac_pkg::SAC_IDLE;
                sac_pkg::SAC_IDLE:
                    state <= sac_pkg::SAC_IDLE;
                default:
                    state <= sac_pkg::SAC_IDLE;
            endcase
        end
    end

    wire complete = (state == sac_pkg::SAC_CONV) & conv_tick & last_bit & ~go;

    // Latch written only on a full conversion, so aborts leave it alone
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            result <= sac_pkg::RESULT_RST;
        else if (complete)
            result <= final_code;
    end

    // Completion sets the flag; a read or a new start clears it
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            done_flag <= 1'b0;
        else if (complete)
            done_flag <= 1'b1;
        else if (read_act | go)
            done_flag <= 1'b0;
    end

    // Free-run pulse timer: start held low while done is low means tied node
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            free_pulse <= 1'b0;
            pulse_cnt <= 6'h00;
        end
        else if (free_start)
        begin
            free_pulse <= 1'b0;
            pulse_cnt <= 6'h00;
        end
        else if (done_flag & sel_act & ~start_n)
        begin
            free_pulse <= 1'b1;
            pulse_cnt <= pulse_cnt + 6'h01;
        end
        else
        begin
            free_pulse <= 1'b0;
            pulse_cnt <= 6'h00;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            data_o <= sac_pkg::RESULT_RST;
            data_oe_n_o <= 1'b1;
        end
        else
        begin
            data_o <= result;
            data_oe_n_o <= ~read_act;
        end
    end

    assign conversion_done_n_o = ~done_flag;
    assign trial_code_o = sar;
    assign sample_o = go;
    assign busy_o = (state == sac_pkg::SAC_CONV);

endmodule : sac_ctrl

// [verilog/sac_pkg.sv]
/*
 * Package for the successive-approximation conversion sequencer: timing
 * constants, code widths, state encoding and the grouped strobe carrier.
 * Assumes a single 125 MHz system clock.
 */
package sac_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned CLK_PERIOD_PS = 8000;
    // Self-terminating completion pulse in free-running mode
    localparam int unsigned FREE_PULSE_NS = 300;
    localparam int unsigned FREE_PULSE_CYC = (FREE_PULSE_NS * 1000) / CLK_PERIOD_PS;
    // Converter clock, unless the external pin is selected, is a divided enable from the system clock
    localparam int unsigned CONV_DIV = 16;
    localparam logic [7:0] CONV_DIV_LAST = 8'(CONV_DIV - 1);
    localparam logic [5:0] FREE_PULSE_LAST = 6'(FREE_PULSE_CYC - 1);
    localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
    localparam logic [DATA_W-1:0] MSB_ONEHOT = 8'h80;
    localparam logic [2:0] SYNC_RST = 3'h7;

    typedef enum logic [2:0] {
        SAC_IDLE = 3'b001,
        SAC_CONV = 3'b010,
        SAC_DONE = 3'b100
    } sac_state_t;

    // Host strobes, all active low
    typedef struct packed {
        logic sel_n;
        logic start_n;
        logic read_n;
    } sac_strobe_t;

endpackage : sac_pkg

// [sim/sac_analog_model.sv]
/* Analog front end: a comparator against a level given in code steps.
   The bench sets the level; the converter's trial code drives it. */
`timescale 1ns/1ps
module sac_analog_model (
    input wire logic [7:0] level_i,
    input wire logic [7:0] trial_code_i,
    output logic comp_below_o
);
    // Equal keeps the bit, so a level of n converts to exactly n
    assign comp_below_o = (trial_code_i <= level_i);
endmodule : sac_analog_model

// [sim/sac_ctrl_props.sv]
/* Port checker for the conversion sequencer.
   Bound to every sac_ctrl instance; one clock, reset high. */
`timescale 1ns/1ps
module sac_ctrl_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sac_pkg::sac_strobe_t strobe_i,
    input wire logic [7:0] trial_code_o,
    input wire logic sample_o,
    input wire logic conversion_done_n_o,
    input wire logic [7:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic busy_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_busy_follows: assert property (sample_o |=> busy_o)
        else $error("busy missing after start");
    a_restart_quiet: assert property (sample_o && busy_o |=> conversion_done_n_o [*2])
        else $error("done pulsed on restart");
    a_abort_latch: assert property (sample_o && busy_o |=> $stable(data_o) [*4])
        else $error("latch moved on abort");
    a_latch_on_done: assert property ($changed(data_o) |-> !conversion_done_n_o)
        else $error("latch moved without done");
    a_done_ends_conv: assert property ($fell(conversion_done_n_o) |->
        $past(busy_o) || $past(busy_o, 2))
        else $error("done without conversion");
    a_trial_msb: assert property (sample_o |-> ##[0:2] trial_code_o == sac_pkg::MSB_ONEHOT)
        else $error("first trial not msb");
    a_oe_needs_read: assert property (strobe_i.read_n [*8] |-> data_oe_n_o)
        else $error("data driven without read");
    a_read_clears: assert property ($fell(data_oe_n_o) |-> ##[0:2] conversion_done_n_o)
        else $error("read left done low");
endmodule : sac_ctrl_props
bind sac_ctrl sac_ctrl_props u_props (.clk_i(clk_i), .rst_i(rst_i), .strobe_i(strobe_i),
    .trial_code_o(trial_code_o), .sample_o(sample_o), .conversion_done_n_o(conversion_done_n_o),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .busy_o(busy_o));

// [sim/tb.sv]
/* Testbench for sac_ctrl: host strobes, restart, external clock, free run.
   Expected codes are queued by the driver and checked at each completion. */
`timescale 1ns/1ps
module tb;
    logic clk_i = 0, rst_i = 1, sel_n = 1, start_r = 1, read_n = 1, free = 0, kick_n = 1;
    logic ext_sel = 0, ext_clk = 0, below, done_n, oe_n, busy, smp;
    logic [7:0] level = 0, trial, data, last;
    logic [7:0] q[$];
    logic [7:0] vals[4] = '{8'h00, 8'h01, 8'hfe, 8'hff};
    int num_errors = 0, comparisons = 0, cycles = 0, seed = 32'h7138720d, n;
    sac_pkg::sac_strobe_t strobe;
    assign strobe = '{sel_n, free ? (done_n & kick_n) : start_r, read_n};
    always #4 clk_i = ~clk_i;
    always #13.3 ext_clk = ~ext_clk;
    sac_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .strobe_i(strobe), .ext_clk_sel_i(ext_sel),
        .ext_clk_i(ext_clk), .comp_below_i(below), .trial_code_o(trial), .sample_o(smp),
        .conversion_done_n_o(done_n), .data_o(data), .data_oe_n_o(oe_n), .busy_o(busy));
    sac_analog_model far (.level_i(level), .trial_code_i(trial), .comp_below_o(below));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask : cyc
    // Start released before select, so the rising start is seen selected
    task start_conv;
        sel_n = 0;
        start_r = 0;
        cyc(6);
        start_r = 1;
        cyc(6);
        sel_n = 1;
    endtask : start_conv
    task convert(input logic [7:0] v);
        level = v;
        q.push_back(v);
        start_conv();
        while (q.size() != 0) cyc(1);
        sel_n = 0;
        read_n = 0;
        cyc(8);
        check({7'h0, oe_n}, 8'h00);
        check({7'h0, done_n}, 8'h01);
        sel_n = 1;
        read_n = 1;
        cyc(8);
    endtask : convert
    always @(negedge done_n)
        if (!rst_i)
        begin
            repeat (2) @(posedge clk_i);
            #1;
            check(data, q.size() != 0 ? q.pop_front() : 8'hxx);
        end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end
    initial
    begin
        cyc(12);
        rst_i = 0;
        cyc(4);
        foreach (vals[i]) convert(vals[i]);
        repeat (3)
        begin
            last = 8'($random(seed));
            convert(last);
        end
        $display("test codes done");
        level = 8'h33;
        start_conv();
        cyc(40);
        level = 8'h77;
        start_conv();
        cyc(40);
        check(data, last);
        check({7'h0, done_n}, 8'h01);
        convert(8'hc4);
        $display("test restart done");
        ext_sel = 1;
        convert(8'ha5);
        ext_sel = 0;
        $display("test external clock done");
        level = 8'h5a;
        repeat (3) q.push_back(8'h5a);
        free = 1;
        sel_n = 0;
        kick_n = 0;
        cyc(4);
        kick_n = 1;
        @(negedge done_n);
        n = 0;
        while (!done_n && n < 200)
        begin
            cyc(1);
            n++;
        end
        check(8'(n >= sac_pkg::FREE_PULSE_CYC && n <= sac_pkg::FREE_PULSE_CYC + 8), 8'h01);
        while (q.size() != 0) cyc(1);
        $display("test free run done");
        stop_test();
    end
endmodule : tb
